// [dv/bcmd_hub_model.sv]
`timescale 1ns/1ps
// ==========================================================================
// far end of the hub link: counts system error messages received
module bcmd_hub_model
(
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       syserr_msg_i,  // one-cycle message request
	output logic      [7:0] msg_count_o    // messages seen since reset
);
	// one message per cycle the request stands high
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			msg_count_o <= 8'h00;
		else if (syserr_msg_i)
			msg_count_o <= msg_count_o + 8'h01;
	end
endmodule // bcmd_hub_model

// [dv/tb_top.sv]
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the bridge command block
module tb_top;
	import bcmd_pkg::*;
	logic        sys_clk_i, sys_rst_i, cfg_wr_i, cfg_rd_i;
	logic        err_i, mem_hit_i, io_hit_i, cfg_rvalid_o;
	logic        syserr_msg_o, mem_fwd_o, io_fwd_o, mem_en, io_en;
	logic [7:0]  cfg_addr_i, msg_count;
	logic [3:0]  cfg_be_i;
	logic [31:0] cfg_wdata_i, cfg_rdata_o;
	int          fail_count, samples_checked;
	// rows: written command (high half), command read back (low half)
	logic [31:0] rows [6] = '{32'hffff_0107, 32'h0000_0000,
		32'h0106_0106, 32'h02f8_0000, 32'hfc20_0000, 32'h0001_0001};
	bcmd_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
		.cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .err_i(err_i),
		.mem_hit_i(mem_hit_i), .io_hit_i(io_hit_i),
		.cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
		.syserr_msg_o(syserr_msg_o), .mem_fwd_o(mem_fwd_o),
		.io_fwd_o(io_fwd_o), .mem_window_enable_o(mem_en),
		.io_window_enable_o(io_en));
	bcmd_hub_model hub (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.syserr_msg_i(syserr_msg_o), .msg_count_o(msg_count));
	// ==========================================================================
	// clock and shared tasks
	initial
	begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// inputs move 1 ns after the edge, never on it
	task automatic step();
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		step();
		cfg_wr_i = 1'b1;
		cfg_addr_i = a;
		cfg_be_i = be;
		cfg_wdata_i = d;
		step();
		cfg_wr_i = 1'b0;
	endtask
	// rvalid stands one cycle, so it is looked at right after the take
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		step();
		cfg_rd_i = 1'b1;
		cfg_addr_i = a;
		step();
		cfg_rd_i = 1'b0;
		chk({31'h0, cfg_rvalid_o}, 32'h1, "read valid");
		chk(cfg_rdata_o, exp, "read data");
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================================
	// watchdog: whole run needs well under 2 us
	initial
	begin
		#50us;
		fail_count++;
		summarize();
	end
	// ==========================================================================
	// main sequence
	initial
	begin
		{cfg_wr_i, cfg_rd_i, err_i, mem_hit_i, io_hit_i} = 5'h00;
		{cfg_addr_i, cfg_be_i, cfg_wdata_i} = 44'h0;
		fail_count = 0;
		samples_checked = 0;
		sys_rst_i = 1'b1;
		repeat (8) step();
		sys_rst_i = 1'b0;
		rdchk(BCMD_CMD_OFFSET, 32'h00a0_0000);
		// table: writable, hardwired and reserved bits
		foreach (rows[i])
		begin
			wr(BCMD_CMD_OFFSET, 4'h3, {16'h0, rows[i][31:16]});
			rdchk(BCMD_CMD_OFFSET, {16'h00a0, rows[i][15:0]});
			chk({30'h0, mem_en, io_en}, {30'h0, rows[i][1:0]},
				"enables");
		end
		$display("test done: register table");
		// error with the enable clear gives nothing
		wr(BCMD_CMD_OFFSET, 4'h3, 32'h0);
		step();
		err_i = 1'b1;
		step();
		err_i = 1'b0;
		chk({31'h0, syserr_msg_o}, 32'h0, "msg while off");
		rdchk(BCMD_CMD_OFFSET, 32'h00a0_0000);
		wr(BCMD_CMD_OFFSET, 4'h3, 32'h0100);
		step();
		err_i = 1'b1;
		step();
		err_i = 1'b0;
		chk({31'h0, syserr_msg_o}, 32'h1, "msg while on");
		step();
		rdchk(BCMD_CMD_OFFSET, 32'h40a0_0100);
		wr(BCMD_CMD_OFFSET, 4'h8, 32'h4000_0000);
		rdchk(BCMD_CMD_OFFSET, 32'h00a0_0100);
		chk({24'h0, msg_count}, 32'h1, "link messages");
		// a clear that meets a fresh message in one cycle: set wins
		step();
		err_i = 1'b1;
		step();
		err_i = 1'b0;
		cfg_wr_i = 1'b1;
		cfg_addr_i = BCMD_CMD_OFFSET;
		cfg_be_i = 4'h8;
		cfg_wdata_i = 32'h4000_0000;
		step();
		cfg_wr_i = 1'b0;
		rdchk(BCMD_CMD_OFFSET, 32'h40a0_0100);
		wr(BCMD_CMD_OFFSET, 4'h8, 32'h4000_0000);
		chk({24'h0, msg_count}, 32'h2, "link messages");
		$display("test done: error message");
		// forwarding gated by the window enables
		mem_hit_i = 1'b1;
		io_hit_i = 1'b1;
		step();
		step();
		chk({30'h0, mem_fwd_o, io_fwd_o}, 32'h0, "fwd off");
		wr(BCMD_CMD_OFFSET, 4'h1, 32'h0003);
		step();
		chk({30'h0, mem_fwd_o, io_fwd_o}, 32'h3, "fwd on");
		// i/o enable dropped alone: memory still forwards
		wr(BCMD_CMD_OFFSET, 4'h1, 32'h0002);
		step();
		chk({30'h0, mem_fwd_o, io_fwd_o}, 32'h2, "fwd mem");
		mem_hit_i = 1'b0;
		io_hit_i = 1'b0;
		$display("test done: forwarding");
		// unmapped space and a second reset
		wr(8'h20, 4'hf, 32'hffff_ffff);
		rdchk(8'h08, 32'h0);
		rdchk(BCMD_CMD_OFFSET, 32'h00a0_0102);
		sys_rst_i = 1'b1;
		step();
		step();
		sys_rst_i = 1'b0;
		rdchk(BCMD_CMD_OFFSET, 32'h00a0_0000);
		$display("test done: unmapped and reset");
		summarize();
	end
endmodule // tb_top

// [src/bcmd_pkg.sv]
// ==========================================================================
// constants of the bridge command block
package bcmd_pkg;
	// config space word that holds command (low) and status (high)
	localparam logic [7:0]  BCMD_CMD_OFFSET   = 8'h04;
	localparam logic [15:0] BCMD_CMD_RESET    = 16'h0000;
	localparam logic [15:0] BCMD_STS_RESET    = 16'h00a0;
	// command bit positions
	localparam int BCMD_IO_EN_BIT   = 0;
	localparam int BCMD_MEM_EN_BIT  = 1;
	localparam int BCMD_BME_BIT     = 2;
	localparam int BCMD_SCE_BIT     = 3;
	localparam int BCMD_MWI_BIT     = 4;
	localparam int BCMD_PERR_BIT    = 6;
	localparam int BCMD_STEP_BIT    = 7;
	localparam int BCMD_SERR_BIT    = 8;
	localparam int BCMD_FB2B_BIT    = 9;
	// writable command bits: serr, bus master, memory, i/o
	localparam logic [15:0] BCMD_CMD_WMASK    = 16'h0107;
	// status: signaled system error, write-one-to-clear
	localparam int BCMD_STS_SSE_BIT = 14;
	// status hardwired ones: fast b2b capable (7), 66 MHz (5)
	localparam logic [15:0] BCMD_STS_FIXED    = 16'h00a0;
endpackage : bcmd_pkg

// [src/bcmd_serr_gen.sv]
`timescale 1ns/1ps
// ==========================================================================
// system error message generator
module bcmd_serr_gen
	import bcmd_pkg::*;
(
	input  wire logic  sys_clk_i,
	input  wire logic  sys_rst_i,
	bcmd_serr_if.gen   serr
);
	logic msg_d;  // next message request
	logic msg_q;  // registered message request

	// message only while enabled; no pin, the hub link carries it
	assign msg_d = serr.enable & serr.err;
	assign serr.msg = msg_q;

	// ======================================================================
	// message register
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			msg_q <= 1'b0;
		else
			msg_q <= msg_d;
	end

	// ======================================================================
	// checks
	serr_gated_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		!$past(serr.enable) |-> !msg_q)
		else $error("message sent while disabled");
	serr_sent_a : assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		serr.enable && serr.err |=> msg_q)
		else $error("enabled error sent no message");
endmodule // bcmd_serr_gen

// [src/bcmd_serr_if.sv]
`timescale 1ns/1ps
// ==========================================================================
// link between the register bank and the error message generator
interface bcmd_serr_if;
	logic enable;  // this function's serr message enable
	logic err;     // enabled error condition, pulse
	logic msg;     // message request, one cycle
	modport gen (input enable, input err, output msg);
	modport bank (output enable, output err, input msg);
endinterface : bcmd_serr_if

// [src/bcmd_top.sv]
`timescale 1ns/1ps
// Operation
// - 16-bit command at 04h, resets zero
// - fast back-to-back bit 9 reads zero
// - stepping bit 7 reads zero
// - parity response bit 6 reads zero
// - bits 4 and 3 read zero
// - bus master bit 2 stored only
// - enabled errors send message when bit 8
// - bit 8 clear sends no message
// - errors signalled only as link messages
// - enable covers this function only
// - status register reports signaled system error
// - bit 1 gates memory window forwarding
// - bit 0 gates i/o window forwarding
// - status bit 14 set, write-one clears
module bcmd_top
	import bcmd_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        cfg_wr_i,      // config write strobe
	input  wire logic        cfg_rd_i,      // config read strobe
	input  wire logic [7:0]  cfg_addr_i,    // config byte offset
	input  wire logic [3:0]  cfg_be_i,      // byte enables
	input  wire logic [31:0] cfg_wdata_i,   // config write data
	input  wire logic        err_i,         // error already enabled by ctrl
	input  wire logic        mem_hit_i,     // access hits memory windows
	input  wire logic        io_hit_i,      // access hits i/o window
	output logic [31:0]      cfg_rdata_o,   // read data
	output logic             cfg_rvalid_o,  // read data valid
	output logic             syserr_msg_o,  // message request to hub link
	output logic             mem_fwd_o,     // forward memory access
	output logic             io_fwd_o,      // forward i/o access
	output logic             mem_window_enable_o,
	output logic             io_window_enable_o
);
	// ======================================================================
	// declarations
	logic [15:0] cmd_q;        // bridge_command storage
	logic [15:0] cmd_d;        // next command value
	logic        sse_q;        // signaled system error flag
	logic        sse_d;        // next flag value
	logic [31:0] rdata_q;      // held read data
	logic [31:0] rdata_d;      // word picked for a read
	logic        rvalid_q;     // read data valid pulse
	logic        mem_fwd_q;    // gated memory forward
	logic        io_fwd_q;     // gated i/o forward
	logic        hit;          // offset matches our word
	logic        wr_cmd;       // write to command half
	logic [15:0] cmd_wdata;    // write data cut to writable bits
	logic [15:0] cmd_be_mask;  // bit mask from byte enables
	logic        sse_clr;      // write one to status bit 14
	logic [15:0] sts_rd;       // primary_status as read

	// enable, enabled error and message shared with the generator
	bcmd_serr_if serr ();

	// ======================================================================
	// decode
	// only the word index is compared; byte lanes pick the halves
	// lanes 0 and 1 load the command, lane 3 clears the status flag
	assign hit = (cfg_addr_i[7:2] == BCMD_CMD_OFFSET[7:2]);
	assign wr_cmd = cfg_wr_i & hit & (cfg_be_i[1:0] != 2'b00);
	assign cmd_be_mask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
	// only the four storage bits take writes; the rest stay zero
	assign cmd_wdata = cfg_wdata_i[15:0] & BCMD_CMD_WMASK;
	assign cmd_d = (cmd_q & ~(cmd_be_mask & BCMD_CMD_WMASK))
		| (cmd_wdata & cmd_be_mask);
	assign sse_clr = cfg_wr_i & hit & cfg_be_i[3]
		& cfg_wdata_i[16 + BCMD_STS_SSE_BIT];
	// set wins over a clear in the same cycle
	assign sse_d = serr.msg | (sse_q & ~sse_clr);
	assign sts_rd = BCMD_STS_FIXED
		| ({15'h0000, sse_q} << BCMD_STS_SSE_BIT);
	// a read beside a write in one cycle returns the old word
	assign rdata_d = hit ? {sts_rd, cmd_q} : 32'h0000_0000;

	// ======================================================================
	// system error path
	// this function's own enable; the host function has another
	assign serr.enable = cmd_q[BCMD_SERR_BIT];
	assign serr.err = err_i;

	bcmd_serr_gen u_gen (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.serr      (serr)
	);

	// ======================================================================
	// command register
	// loads only when a write touches a command lane
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			cmd_q <= BCMD_CMD_RESET;
		else if (wr_cmd)
			cmd_q <= cmd_d;
	end

	// ======================================================================
	// status flag
	// the message itself sets it, so no event is ever lost
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
			sse_q <= 1'b0;
		else
			sse_q <= sse_d;
	end

	// ======================================================================
	// read port, one cycle latency; unmapped offsets read zero
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= cfg_rd_i;
			// held between reads for a slow reader
			if (cfg_rd_i)
				rdata_q <= rdata_d;
		end
	end

	// ======================================================================
	// forwarding gates, registered so outputs come from flops
	// limitation: the forward lags the hit by one cycle
	always_ff @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			mem_fwd_q <= 1'b0;
			io_fwd_q  <= 1'b0;
		end
		else
		begin
			mem_fwd_q <= mem_hit_i & cmd_q[BCMD_MEM_EN_BIT];
			io_fwd_q  <= io_hit_i & cmd_q[BCMD_IO_EN_BIT];
		end
	end

	// ======================================================================
	// outputs, each straight from a flop
	assign cfg_rdata_o         = rdata_q;
	assign cfg_rvalid_o        = rvalid_q;
	assign syserr_msg_o        = serr.msg;
	assign mem_fwd_o           = mem_fwd_q;
	assign io_fwd_o            = io_fwd_q;
	// raw enables let the window compare skip lookups when off
	assign mem_window_enable_o = cmd_q[BCMD_MEM_EN_BIT];
	assign io_window_enable_o  = cmd_q[BCMD_IO_EN_BIT];

	// ======================================================================
	// checks
	// all checks run on the core clock and rest during reset
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	fixed_zero_a : assert property (
		(cmd_q & ~BCMD_CMD_WMASK) == 16'h0000)
		else $error("hardwired command bit set");
	reset_zero_a : assert property (
		$past(sys_rst_i) |-> cmd_q == BCMD_CMD_RESET)
		else $error("command not zero after reset");
	bme_store_a : assert property (
		wr_cmd && cfg_be_i[0] |=> cmd_q[BCMD_BME_BIT]
		== $past(cfg_wdata_i[BCMD_BME_BIT]))
		else $error("bus master bit not stored");
	mem_gate_a : assert property (
		mem_hit_i && !cmd_q[BCMD_MEM_EN_BIT] |=> !mem_fwd_o)
		else $error("memory forwarded while disabled");
	io_gate_a : assert property (
		io_hit_i ##1 io_fwd_o |-> $past(cmd_q[BCMD_IO_EN_BIT]))
		else $error("io forwarded while disabled");
	msg_path_a : assert property (
		err_i && cmd_q[BCMD_SERR_BIT] |=> syserr_msg_o ##1 sse_q)
		else $error("error did not reach message and status");
	no_msg_a : assert property (
		!cmd_q[BCMD_SERR_BIT] && !syserr_msg_o |=> !syserr_msg_o)
		else $error("message while enable clear");
	sse_hold_a : assert property (
		sse_q && !sse_clr |=> sse_q)
		else $error("status flag lost");
	sse_clear_a : assert property (
		sse_clr && !syserr_msg_o |=> !sse_q)
		else $error("status flag not cleared");
	read_zero_a : assert property (
		cfg_rvalid_o |-> cfg_rdata_o[15:10] == 6'h00
		&& !cfg_rdata_o[5] && cfg_rdata_o[4:3] == 2'b00)
		else $error("reserved bits read non-zero");

	// ======================================================================
	// read latency, status view, flag set and open windows
	read_back_a : assert property (
		cfg_rd_i && hit |=> cfg_rvalid_o
		&& cfg_rdata_o[15:0] == $past(cmd_q))
		else $error("command read back wrong");
	status_view_a : assert property (
		cfg_rd_i && hit |=> cfg_rdata_o[16 + BCMD_STS_SSE_BIT]
		== $past(sse_q))
		else $error("status read does not show flag");
	sse_set_a : assert property (
		syserr_msg_o |=> sse_q)
		else $error("message did not set status flag");
	mem_open_a : assert property (
		mem_hit_i && cmd_q[BCMD_MEM_EN_BIT] |=> mem_fwd_o)
		else $error("enabled memory access not forwarded");
	io_open_a : assert property (
		io_hit_i && cmd_q[BCMD_IO_EN_BIT] |=> io_fwd_o)
		else $error("enabled io access not forwarded");

	msg_sent_c : cover property (err_i && cmd_q[BCMD_SERR_BIT]);
	set_clear_c : cover property (sse_clr && syserr_msg_o);
	mem_fwd_c : cover property (mem_fwd_o);
	io_fwd_c : cover property (io_fwd_o);
	clr_only_c : cover property (sse_clr && sse_q && !syserr_msg_o);
endmodule // bcmd_top
